// File: design/tsbs_buffer_pool.sv
//----------------------------------------------------------------------
// tsbs_buffer_pool
//----------------------------------------------------------------------
// Purpose: bulk/control split buffers between high- and full-speed sides
// Assumes: start- and complete-splits never arrive in the same cycle
// Notes: IN data go to the host through a two-entry valid/ready buffer
`timescale 1ns/1ps
module tsbs_buffer_pool
   import tsbs_pkg::*;
#(
   parameter int NB = NUM_BUFS,
   parameter int NBYTES = MAX_BYTES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // start-split token
   input wire logic ss_valid,
   input wire logic [DEV_W-1:0] ss_dev,
   input wire logic [EP_W-1:0] ss_ep,
   input wire logic ss_in,
   input wire logic ss_ctl,
   // OUT payload after an accepted start-split
   input wire logic od_valid,
   input wire logic [7:0] od_byte,
   input wire logic od_last,
   // complete-split token
   input wire logic cs_valid,
   input wire logic [DEV_W-1:0] cs_dev,
   input wire logic [EP_W-1:0] cs_ep,
   input wire logic cs_in,
   input wire logic cs_ctl,
   // reply to the high-speed handler
   output tsbs_rep_t rep_code_r,
   output tsbs_res_t rep_res_r,
   output logic rep_valid_r,
   // IN data toward the host
   output logic id_valid_r,
   output logic [7:0] id_byte_r,
   output logic id_last_r,
   input wire logic id_ready,
   // downstream handler: job offer
   output logic fs_avail_r,
   output logic [DEV_W-1:0] fs_dev_r,
   output logic [EP_W-1:0] fs_ep_r,
   output logic fs_in_r,
   output logic fs_ctl_r,
   output logic [$clog2(NBYTES):0] fs_len_r,
   input wire logic fs_start,
   // downstream handler: payload access
   input wire logic fs_rd_en,
   input wire logic [$clog2(NBYTES)-1:0] fs_rd_addr,
   output logic [7:0] fs_rd_byte,
   output logic fs_rd_ok_r,
   output logic fs_wr_ok_r,
   input wire logic fs_wr_en,
   input wire logic [7:0] fs_wr_byte,
   // downstream handler: completion
   input wire logic fs_done,
   input wire tsbs_res_t fs_result,
   input wire logic [ERR_W-1:0] fs_err
);
   localparam int IW = (NB > 1) ? $clog2(NB) : 1;
   localparam int PW = $clog2(NBYTES);
   localparam int LW = PW + 1;

   //-------------------------------------------------------------------
   // buffer state
   //-------------------------------------------------------------------
   tsbs_stat_t stat_r [NB], stat_nxt [NB];
   tsbs_res_t res_r [NB], res_nxt [NB];
   logic [DEV_W-1:0] dev_r [NB], dev_nxt [NB];
   logic [EP_W-1:0] ep_r [NB], ep_nxt [NB];
   logic in_r [NB], in_nxt [NB];
   logic ctl_r [NB], ctl_nxt [NB];
   logic [LW-1:0] len_r [NB], len_nxt [NB];
   // OUT payload capture
   logic od_act_r, od_act_nxt, od_drop_r, od_drop_nxt;
   logic [IW-1:0] od_idx_r, od_idx_nxt;
   logic [LW-1:0] od_ptr_r, od_ptr_nxt;
   // downstream job
   logic busy_r, busy_nxt;
   logic [IW-1:0] cur_r, cur_nxt, rr_r, rr_nxt, fs_idx_r, fs_idx_nxt;
   logic [LW-1:0] fw_ptr_r, fw_ptr_nxt;
   logic fs_avail_nxt, fs_in_nxt, fs_ctl_nxt;
   logic [DEV_W-1:0] fs_dev_nxt;
   logic [EP_W-1:0] fs_ep_nxt;
   logic [LW-1:0] fs_len_nxt;
   // reply
   tsbs_rep_t rep_code_nxt;
   tsbs_res_t rep_res_nxt;
   logic rep_valid_nxt;
   // lookup results
   logic ss_new, ss_old, cs_hit;
   logic [IW-1:0] ss_idx, cs_idx;

   // endpoint compare, control leaves direction out
   function automatic logic ep_match(input int k,
      input logic [DEV_W-1:0] d, input logic [EP_W-1:0] e,
      input logic dir, input logic ctl);
      ep_match = (dev_r[k] == d) && (ep_r[k] == e) &&
                 (ctl || (in_r[k] == dir));
   endfunction

   // a buffer still being read out cannot be handed to a new job
   logic dr_act_r, dr_act_nxt;
   logic [IW-1:0] dr_idx_r, dr_idx_nxt;

   //-------------------------------------------------------------------
   // lookups: start-split placement and complete-split hit
   //-------------------------------------------------------------------
   // last free buffer wins unless the endpoint already owns one
   always_comb begin
      logic found;
      found = 1'b0;
      ss_new = 1'b0;
      ss_old = 1'b0;
      ss_idx = '0;
      cs_hit = 1'b0;
      cs_idx = '0;
      for (int i = 0; i < NB; i++) begin
         if (!found) begin
            if (ep_match(i, ss_dev, ss_ep, ss_in, ss_ctl) &&
                stat_r[i] != ST_OLD) begin
               ss_old = 1'b1;
               ss_new = 1'b0;
               ss_idx = IW'(i);
               found = 1'b1;
            end else if (stat_r[i] == ST_OLD &&
                         !(dr_act_r && dr_idx_r == IW'(i))) begin
               ss_new = 1'b1;
               ss_idx = IW'(i);
               found = ep_match(i, ss_dev, ss_ep, ss_in, ss_ctl);
            end
         end
         if (!cs_hit && ep_match(i, cs_dev, cs_ep, cs_in, cs_ctl)) begin
            cs_hit = 1'b1;
            cs_idx = IW'(i);
         end
      end
   end

   //-------------------------------------------------------------------
   // buffer updates, payload pointers and replies
   //-------------------------------------------------------------------
   logic dr_go;
   logic mw_en;
   logic [IW+PW-1:0] mw_addr;
   logic [7:0] mw_data;

   always_comb begin
      stat_nxt = stat_r;
      res_nxt = res_r;
      dev_nxt = dev_r;
      ep_nxt = ep_r;
      in_nxt = in_r;
      ctl_nxt = ctl_r;
      len_nxt = len_r;
      od_act_nxt = od_act_r;
      od_drop_nxt = od_drop_r;
      od_idx_nxt = od_idx_r;
      od_ptr_nxt = od_ptr_r;
      busy_nxt = busy_r;
      cur_nxt = cur_r;
      fw_ptr_nxt = fw_ptr_r;
      rep_valid_nxt = 1'b0;
      rep_code_nxt = rep_code_r;
      rep_res_nxt = rep_res_r;
      dr_go = 1'b0;
      mw_en = 1'b0;
      mw_addr = '0;
      mw_data = '0;
      // start-split: store token or refuse for lack of room
      if (ss_valid) begin
         rep_valid_nxt = 1'b1;
         if (ss_old) begin
            rep_code_nxt = RP_ACK;
            od_act_nxt = !ss_in;
            od_drop_nxt = 1'b1;
         end else if (ss_new) begin
            rep_code_nxt = RP_ACK;
            stat_nxt[ss_idx] = ST_PEND;
            dev_nxt[ss_idx] = ss_dev;
            ep_nxt[ss_idx] = ss_ep;
            in_nxt[ss_idx] = ss_in;
            ctl_nxt[ss_idx] = ss_ctl;
            len_nxt[ss_idx] = '0;
            od_act_nxt = !ss_in;
            od_drop_nxt = 1'b0;
            od_idx_nxt = ss_idx;
         end else begin
            rep_code_nxt = RP_NAK;
         end
         od_ptr_nxt = '0;
      end else if (cs_valid) begin
         // complete-split: answer from stored status
         rep_valid_nxt = 1'b1;
         rep_res_nxt = res_r[cs_idx];
         if (!cs_hit) begin
            rep_code_nxt = RP_NONE;
         end else if (stat_r[cs_idx] == ST_PEND) begin
            rep_code_nxt = RP_NYET;
         end else begin
            rep_code_nxt = RP_RES;
            stat_nxt[cs_idx] = ST_OLD;
            dr_go = in_r[cs_idx] && len_r[cs_idx] != '0 &&
                    !dr_act_r;
         end
      end
      // OUT payload bytes, dropped for a retried start-split
      if (od_act_r && od_valid) begin
         if (!od_drop_r && od_ptr_r < LW'(NBYTES)) begin
            mw_en = 1'b1;
            mw_addr = {od_idx_r, od_ptr_r[PW-1:0]};
            mw_data = od_byte;
            od_ptr_nxt = od_ptr_r + 1'b1;
         end
         if (od_last) begin
            od_act_nxt = 1'b0;
            if (!od_drop_r) begin
               len_nxt[od_idx_r] = mw_en ? od_ptr_r + 1'b1 : od_ptr_r;
            end
         end
      end
      // downstream job start, IN bytes and completion
      if (fs_start && fs_avail_r && !busy_r) begin
         busy_nxt = 1'b1;
         cur_nxt = fs_idx_r;
         fw_ptr_nxt = '0;
      end
      if (busy_r && fs_wr_en && !od_act_r &&
          fw_ptr_r < LW'(NBYTES)) begin
         mw_en = 1'b1;
         mw_addr = {cur_r, fw_ptr_r[PW-1:0]};
         mw_data = fs_wr_byte;
         fw_ptr_nxt = fw_ptr_r + 1'b1;
      end
      if (busy_r && fs_done) begin
         busy_nxt = 1'b0;
         stat_nxt[cur_r] = ST_READY;
         // any error flag overrides the reported handshake
         res_nxt[cur_r] = (|fs_err) ? RS_ERR : fs_result;
         if (in_r[cur_r]) begin
            len_nxt[cur_r] = fw_ptr_r;
         end
      end
   end

   // offer the next pending buffer, round robin
   always_comb begin
      logic got;
      logic [IW-1:0] k;
      got = 1'b0;
      k = '0;
      fs_idx_nxt = fs_idx_r;
      rr_nxt = rr_r;
      for (int j = 0; j < NB; j++) begin
         k = IW'((int'(rr_r) + j) % NB);
         if (!got && stat_r[k] == ST_PEND &&
             !(od_act_r && od_idx_r == k)) begin
            got = 1'b1;
            fs_idx_nxt = k;
         end
      end
      fs_avail_nxt = got && !busy_nxt;
      if (fs_start && fs_avail_r && !busy_r) begin
         rr_nxt = IW'((int'(fs_idx_r) + 1) % NB);
      end
      fs_dev_nxt = dev_r[fs_idx_nxt];
      fs_ep_nxt = ep_r[fs_idx_nxt];
      fs_in_nxt = in_r[fs_idx_nxt];
      fs_ctl_nxt = ctl_r[fs_idx_nxt];
      fs_len_nxt = len_r[fs_idx_nxt];
   end

   // reset leaves every buffer old
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NB; i++) begin
            stat_r[i] <= ST_OLD;
            res_r[i] <= RS_NAK;
            dev_r[i] <= '0;
            ep_r[i] <= '0;
            in_r[i] <= 1'b0;
            ctl_r[i] <= 1'b0;
            len_r[i] <= '0;
         end
         od_act_r <= 1'b0;
         od_drop_r <= 1'b0;
         od_idx_r <= '0;
         od_ptr_r <= '0;
         busy_r <= 1'b0;
         cur_r <= '0;
         fw_ptr_r <= '0;
         rr_r <= '0;
         fs_idx_r <= '0;
         fs_avail_r <= 1'b0;
         fs_dev_r <= '0;
         fs_ep_r <= '0;
         fs_in_r <= 1'b0;
         fs_ctl_r <= 1'b0;
         fs_len_r <= '0;
         rep_valid_r <= 1'b0;
         rep_code_r <= RP_NONE;
         rep_res_r <= RS_NAK;
      end else begin
         stat_r <= stat_nxt;
         res_r <= res_nxt;
         dev_r <= dev_nxt;
         ep_r <= ep_nxt;
         in_r <= in_nxt;
         ctl_r <= ctl_nxt;
         len_r <= len_nxt;
         od_act_r <= od_act_nxt;
         od_drop_r <= od_drop_nxt;
         od_idx_r <= od_idx_nxt;
         od_ptr_r <= od_ptr_nxt;
         busy_r <= busy_nxt;
         cur_r <= cur_nxt;
         fw_ptr_r <= fw_ptr_nxt;
         rr_r <= rr_nxt;
         fs_idx_r <= fs_idx_nxt;
         fs_avail_r <= fs_avail_nxt;
         fs_dev_r <= fs_dev_nxt;
         fs_ep_r <= fs_ep_nxt;
         fs_in_r <= fs_in_nxt;
         fs_ctl_r <= fs_ctl_nxt;
         fs_len_r <= fs_len_nxt;
         rep_valid_r <= rep_valid_nxt;
         rep_code_r <= rep_code_nxt;
         rep_res_r <= rep_res_nxt;
      end
   end

   //-------------------------------------------------------------------
   // IN data read-out through a two-entry buffer
   //-------------------------------------------------------------------
   logic [LW-1:0] dr_ptr_r, dr_ptr_nxt, dr_len_r, dr_len_nxt;
   logic fly_r, fly_nxt, fly_last_r, fly_last_nxt;
   logic [7:0] q_byte_r [FIFO_DEPTH], q_byte_nxt [FIFO_DEPTH];
   logic q_last_r [FIFO_DEPTH], q_last_nxt [FIFO_DEPTH];
   logic [1:0] q_cnt_r, q_cnt_nxt;
   logic issue, pop;
   logic [7:0] mem_q;

   // reads are issued only with room for them, so a stall loses nothing
   always_comb begin
      dr_act_nxt = dr_act_r;
      dr_idx_nxt = dr_idx_r;
      dr_ptr_nxt = dr_ptr_r;
      dr_len_nxt = dr_len_r;
      q_byte_nxt = q_byte_r;
      q_last_nxt = q_last_r;
      q_cnt_nxt = q_cnt_r;
      pop = id_valid_r && id_ready;
      issue = dr_act_r && dr_ptr_r < dr_len_r &&
              (2'(q_cnt_r) + 2'(fly_r)) < 2'(FIFO_DEPTH);
      fly_nxt = issue;
      fly_last_nxt = issue && (dr_ptr_r + 1'b1 == dr_len_r);
      if (dr_go) begin
         dr_act_nxt = 1'b1;
         dr_idx_nxt = cs_idx;
         dr_ptr_nxt = '0;
         dr_len_nxt = len_r[cs_idx];
      end
      if (issue) begin
         dr_ptr_nxt = dr_ptr_r + 1'b1;
      end
      if (pop) begin
         q_byte_nxt[0] = q_byte_r[1];
         q_last_nxt[0] = q_last_r[1];
         q_cnt_nxt = q_cnt_nxt - 1'b1;
      end
      if (fly_r) begin
         q_byte_nxt[q_cnt_nxt[0]] = mem_q;
         q_last_nxt[q_cnt_nxt[0]] = fly_last_r;
         q_cnt_nxt = q_cnt_nxt + 1'b1;
         if (fly_last_r) begin
            dr_act_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dr_act_r <= 1'b0;
         dr_idx_r <= '0;
         dr_ptr_r <= '0;
         dr_len_r <= '0;
         fly_r <= 1'b0;
         fly_last_r <= 1'b0;
         q_byte_r <= '{default: '0};
         q_last_r <= '{default: 1'b0};
         q_cnt_r <= '0;
         id_valid_r <= 1'b0;
         id_byte_r <= '0;
         id_last_r <= 1'b0;
         fs_rd_ok_r <= 1'b0;
         fs_wr_ok_r <= 1'b0;
      end else begin
         dr_act_r <= dr_act_nxt;
         dr_idx_r <= dr_idx_nxt;
         dr_ptr_r <= dr_ptr_nxt;
         dr_len_r <= dr_len_nxt;
         fly_r <= fly_nxt;
         fly_last_r <= fly_last_nxt;
         q_byte_r <= q_byte_nxt;
         q_last_r <= q_last_nxt;
         q_cnt_r <= q_cnt_nxt;
         id_valid_r <= q_cnt_nxt != '0;
         id_byte_r <= q_byte_nxt[0];
         id_last_r <= q_last_nxt[0];
         fs_rd_ok_r <= !dr_act_nxt && !dr_go;
         fs_wr_ok_r <= !od_act_nxt;
      end
   end

   // read port: read-out first, downstream handler otherwise
   tsbs_mem #(.DW(8), .AW(IW + PW)) u_mem (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(mw_en),
      .wr_addr(mw_addr),
      .wr_data(mw_data),
      .rd_en(issue || (fs_rd_en && !dr_act_r)),
      .rd_addr(issue ? {dr_idx_r, dr_ptr_r[PW-1:0]}
                     : {cur_r, fs_rd_addr}),
      .rd_data(mem_q)
   );
   assign fs_rd_byte = mem_q;

   //-------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------
   a_nak_no_room: assert property (@(posedge clk) disable iff (sys_rst)
      ss_valid && !ss_new && !ss_old |=> rep_valid_r && rep_code_r == RP_NAK)
      else $error("start-split without room not refused");
   a_ack_room: assert property (@(posedge clk) disable iff (sys_rst)
      ss_valid && ss_new |=> rep_code_r == RP_ACK &&
      stat_r[$past(ss_idx)] == ST_PEND)
      else $error("accepted start-split not stored");
   a_retry_drop: assert property (@(posedge clk) disable iff (sys_rst)
      ss_valid && ss_old |=> rep_code_r == RP_ACK && od_drop_r &&
      !(od_act_r && mw_en))
      else $error("retried start-split payload kept");
   a_cs_to_old: assert property (@(posedge clk) disable iff (sys_rst)
      cs_valid && !ss_valid && cs_hit && stat_r[cs_idx] == ST_READY
      |=> stat_r[$past(cs_idx)] == ST_OLD && rep_code_r == RP_RES &&
      rep_res_r == $past(res_r[cs_idx]))
      else $error("ready buffer not retired by complete-split");
   a_pend_nyet: assert property (@(posedge clk) disable iff (sys_rst)
      cs_valid && !ss_valid && cs_hit && stat_r[cs_idx] == ST_PEND &&
      !(busy_r && fs_done && cur_r == cs_idx) |=> rep_code_r == RP_NYET)
      else $error("pending buffer answered with a result");
   a_done_ready: assert property (@(posedge clk) disable iff (sys_rst)
      busy_r && fs_done && fs_err == '0 |=> stat_r[$past(cur_r)] ==
      ST_READY && res_r[$past(cur_r)] == $past(fs_result))
      else $error("completion result not recorded");
   a_err_result: assert property (@(posedge clk) disable iff (sys_rst)
      busy_r && fs_done && fs_err != '0 |=> res_r[$past(cur_r)] == RS_ERR)
      else $error("downstream error not recorded");
   a_reset_old: assert property (@(posedge clk)
      sys_rst |=> stat_r[0] == ST_OLD && stat_r[NB-1] == ST_OLD)
      else $error("buffer not old after reset");
   a_fifo_hold: assert property (@(posedge clk) disable iff (sys_rst)
      id_valid_r && !id_ready |=> id_valid_r && $stable(id_byte_r))
      else $error("stalled IN byte changed or lost");
endmodule

// File: design/tsbs_pkg.sv
//----------------------------------------------------------------------
// tsbs_pkg
//----------------------------------------------------------------------
// Purpose: constants and types of the bulk/control split buffer pool
// Assumes: one clock, synchronous active-high reset
// Notes: status and result codes stay inside the translator
//
// Behaviour
// - At least two independent bulk/control transaction buffers exist.
// - Buffer keeps start-split token, OUT payload, then result and IN data.
// - Buffers fill and empty only through high-speed split transactions.
// - Downstream handler updates the buffer while its transaction runs.
// - Start-split is accepted whenever a suitable buffer has room.
// - After complete-split answer the buffer is free for any endpoint; the code holds it back while its IN data are still read out.
// - Acceptance order follows only free space and host try order.
// - Host and translator both keep state for several endpoints.
// - Complete-split answer is chosen from stored downstream status.
// - Finished downstream transaction makes buffer ready with NAK/ACK/STALL.
// - Any downstream transaction error records the error result.
// - PID check, CRC5, bad PID, timeout, CRC16, length, stuff, EOP are errors.
// - Bulk/control IN with good data CRC records the data result.
// - Periodic IN records final data when packet reception completed.
// - Periodic IN records partial data when microframe timer hits mid-packet.
// - Complete-split on a ready buffer moves it to old, result kept.
// - Every buffer starts old, also after reset.
// - Buffer is pending while waiting for the downstream bus.
// - No room for a new start-split gives a NAK reply.
// - Room for a new start-split stores it and replies ACK.
// - Start-split for a pending or ready endpoint: ACK, payload dropped.
// - Match uses address, endpoint, direction; control ignores direction.
//----------------------------------------------------------------------
package tsbs_pkg;
   localparam int NUM_BUFS = 2;
   localparam int DEV_W = 7;
   localparam int EP_W = 4;
   localparam int MAX_BYTES = 64;
   localparam int ERR_W = 8;
   // downstream error flag positions
   localparam int ERR_PID_CHK = 0;
   localparam int ERR_CRC5 = 1;
   localparam int ERR_PID_BAD = 2;
   localparam int ERR_TIMEOUT = 3;
   localparam int ERR_CRC16 = 4;
   localparam int ERR_LENGTH = 5;
   localparam int ERR_STUFF = 6;
   localparam int ERR_EOP = 7;
   localparam int FIFO_DEPTH = 2;

   typedef enum logic [1:0] {ST_OLD, ST_PEND, ST_READY} tsbs_stat_t;
   typedef enum logic [2:0] {
      RS_NAK, RS_ACK, RS_STALL, RS_ERR, RS_DATA, RS_LAST, RS_MORE
   } tsbs_res_t;
   typedef enum logic [2:0] {
      RP_ACK, RP_NAK, RP_NYET, RP_RES, RP_NONE
   } tsbs_rep_t;
endpackage

// File: design/tsbs_mem.sv
//----------------------------------------------------------------------
// tsbs_mem
//----------------------------------------------------------------------
// Purpose: payload store, one write port, one registered read port
// Assumes: caller keeps addresses in range
// Notes: read data appear one cycle after rd_en
`timescale 1ns/1ps
module tsbs_mem #(
   parameter int DW = 8,
   parameter int AW = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [2**AW];

   // storage has no reset, only the read register does
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// File: testbench/tsbs_host_model.sv
//------------------------------------------------------------
// Purpose: host side of the split buffer pool
// Assumes: drives at falling edges, one token at a time
// Notes: id_ready stalls at random to fill the output buffer
//------------------------------------------------------------
`timescale 1ns/1ps
module tsbs_host_model
   import tsbs_pkg::*;
(
   // clock and reply
   input wire logic clk,
   input wire logic rep_valid_r,
   // tokens, payload, read-out ready
   output logic ss_valid,
   output logic cs_valid,
   output logic [DEV_W-1:0] dev,
   output logic [EP_W-1:0] ep,
   output logic dir_in,
   output logic ctl,
   output logic od_valid,
   output logic [7:0] od_byte,
   output logic od_last,
   output logic id_ready
);
   // idle bus at time zero
   initial begin
      {ss_valid, cs_valid, od_valid, od_last, dir_in, ctl} = 6'h00;
      dev = 7'h00;
      ep = 4'h0;
      od_byte = 8'h00;
      id_ready = 1'b0;
   end
   // stall half the time, no byte may be lost
   always @(negedge clk) id_ready <= 1'($urandom_range(1));
   // one token; an OUT start-split carries a single byte
   task automatic tok(input logic s, input logic [EP_W-1:0] e,
      input logic i, input logic c, output logic ok);
      @(negedge clk);
      ss_valid = s;
      cs_valid = !s;
      dev = 7'h05;
      ep = e;
      dir_in = i;
      ctl = c;
      @(negedge clk);
      ok = rep_valid_r;
      ss_valid = 1'b0;
      cs_valid = 1'b0;
      // released lines show garbage, not the last token
      dev = ~dev;
      ep = ~ep;
      dir_in = ~i;
      od_valid = s && !i;
      od_last = s && !i;
      od_byte = 8'($urandom);
      @(negedge clk);
      od_valid = 1'b0;
      od_last = 1'b0;
   endtask
endmodule

// File: testbench/test_tsbs_buffer_pool.sv
//------------------------------------------------------------
// Purpose: self-checking bench of the split buffer pool
// Assumes: one reply per token, held codes
// Notes: per-endpoint model; cleared data are not re-read
//------------------------------------------------------------
`timescale 1ns/1ps
module test_tsbs_buffer_pool
   import tsbs_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ss_valid, cs_valid, dir_in, ctl, od_valid, od_last, id_ready;
   logic [DEV_W-1:0] dev, fs_dev_r;
   logic [EP_W-1:0] ep, fs_ep_r;
   logic [7:0] od_byte, id_byte_r, fs_rd_byte;
   logic [7:0] fs_wr_byte = 8'h00;
   tsbs_rep_t rep_code_r;
   tsbs_res_t rep_res_r;
   tsbs_res_t fs_result = RS_NAK;
   logic rep_valid_r, id_valid_r, id_last_r, fs_avail_r, fs_in_r;
   logic fs_ctl_r, fs_rd_ok_r, fs_wr_ok_r;
   logic fs_start = 1'b0;
   logic fs_wr_en = 1'b0;
   logic fs_done = 1'b0;
   logic fs_rd_en = 1'b0;
   logic [6:0] fs_len_r;
   logic [ERR_W-1:0] fs_err = 8'h00;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   int st[16];
   tsbs_res_t rs[16];
   logic [7:0] ob[16];
   logic [7:0] q[$];
   // design and host model
   tsbs_buffer_pool DUT (.clk, .sys_rst, .ss_valid, .ss_dev(dev),
      .ss_ep(ep), .ss_in(dir_in), .ss_ctl(ctl), .od_valid, .od_byte,
      .od_last, .cs_valid, .cs_dev(dev), .cs_ep(ep), .cs_in(dir_in),
      .cs_ctl(ctl), .rep_code_r, .rep_res_r, .rep_valid_r, .id_valid_r,
      .id_byte_r, .id_last_r, .id_ready, .fs_avail_r, .fs_dev_r,
      .fs_ep_r, .fs_in_r, .fs_ctl_r, .fs_len_r, .fs_start,
      .fs_rd_en, .fs_rd_addr(6'h00), .fs_rd_byte, .fs_rd_ok_r,
      .fs_wr_ok_r, .fs_wr_en, .fs_wr_byte, .fs_done, .fs_result,
      .fs_err);
   tsbs_host_model hc (.clk, .rep_valid_r, .ss_valid, .cs_valid, .dev,
      .ep, .dir_in, .ctl, .od_valid, .od_byte, .od_last, .id_ready);
   always #5 clk = ~clk;
   // hang guard, far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask
   // token with expected reply from the model
   task automatic split(input logic s, input int e, input logic i,
      input logic c);
      int used;
      tsbs_rep_t x;
      logic ok;
      used = 0;
      foreach (st[n]) used += int'(st[n] == 1 || st[n] == 2);
      if (!s) x = st[e] == 1 ? RP_NYET : st[e] == 0 ? RP_NONE : RP_RES;
      else if (st[e] == 1 || st[e] == 2 || used < NUM_BUFS) x = RP_ACK;
      else x = RP_NAK;
      hc.tok(s, 4'(e), i, c, ok);
      chk(8'(ok), 8'h01);
      chk(8'(rep_code_r), 8'(x));
      if (x == RP_RES) chk(8'(rep_res_r), 8'(rs[e]));
      if (s && !i && x == RP_ACK && st[e] != 1 && st[e] != 2)
         ob[e] = hc.od_byte;
      if (s && x == RP_ACK && st[e] != 2) st[e] = 1;
      if (x == RP_RES) st[e] = 3;
   endtask
   // take the offered job, finish it downstream, collect the result
   task automatic job(input tsbs_res_t r, input logic [7:0] er,
      input int n);
      int e, k;
      logic c, d;
      logic [6:0] ln;
      k = 0;
      while (fs_avail_r !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      e = int'(fs_ep_r);
      c = fs_ctl_r;
      d = fs_in_r;
      ln = fs_len_r;
      chk(8'(st[e]), 8'h01);
      chk(8'(fs_dev_r), 8'h05);
      if (!d) chk(8'(ln), 8'h01);
      fs_start = 1'b1;
      @(negedge clk);
      fs_start = 1'b0;
      fs_rd_en = !d;
      chk(8'(fs_avail_r), 8'h00);
      @(negedge clk);
      fs_rd_en = 1'b0;
      chk(8'(fs_rd_ok_r), 8'h01);
      if (!d) chk(fs_rd_byte, ob[e]);
      k = 0;
      while (n > 0 && fs_wr_ok_r !== 1'b1 && k < 5) begin
         @(negedge clk);
         k++;
      end
      for (k = 0; k < n; k++) begin
         fs_wr_en = 1'b1;
         fs_wr_byte = 8'($urandom);
         q.push_back(fs_wr_byte);
         @(negedge clk);
      end
      fs_wr_en = 1'b0;
      fs_done = 1'b1;
      fs_result = r;
      fs_err = er;
      @(negedge clk);
      fs_done = 1'b0;
      fs_err = 8'h00;
      st[e] = 2;
      rs[e] = er != 0 ? RS_ERR : r;
      split(1'b0, e, d, c);
      k = 0;
      // look between edges: a byte is taken at the next rising edge
      while (q.size() > 0 && k < 300) begin
         #1;
         if (id_valid_r === 1'b1 && id_ready === 1'b1) begin
            chk(id_byte_r, q.pop_front());
            chk(8'(id_last_r), 8'(q.size() == 0));
         end
         @(negedge clk);
         k++;
      end
      chk(8'(q.size()), 8'h00);
      if (n == 0) split(1'b0, e, d, c);
      $display("job done ep %0d result %0d", e, rs[e]);
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      void'($urandom(60));
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      split(1'b0, 1, 1'b1, 1'b0);
      split(1'b1, 1, 1'b1, 1'b0);
      split(1'b1, 2, 1'b1, 1'b0);
      split(1'b1, 3, 1'b1, 1'b0);
      split(1'b1, 1, 1'b1, 1'b0);
      split(1'b0, 2, 1'b1, 1'b0);
      $display("fill test done");
      job(RS_DATA, 8'h00, 5);
      job(RS_DATA, 8'h00, 1);
      split(1'b1, 4, 1'b1, 1'b1);
      split(1'b1, 4, 1'b0, 1'b1);
      split(1'b1, 5, 1'b0, 1'b0);
      split(1'b1, 6, 1'b1, 1'b0);
      job(RS_STALL, 8'h00, 0);
      job(RS_ACK, 8'h00, 0);
      $display("match test done");
      // every handshake code, then every error flag alone
      for (int i = 0; i < 15; i++) begin
         split(1'b1, 7, 1'b1, 1'b0);
         job(i < 7 ? tsbs_res_t'(i) : RS_ACK,
            i < 7 ? 8'h00 : 8'h01 << (i - 7), 0);
      end
      tally_and_finish();
   end
endmodule
